/* File: hdl/bbp_port.v */
// byte-wide bit-bang parallel port core
`timescale 1ns/1ps
`include "bbp_defines.vh"
`default_nettype none
module bbp_port #(
   parameter DIV_W = 16
) (
   // clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // mode setup command
   input wire cmd_valid_i,
   input wire [7:0] cmd_mode_i,
   input wire [7:0] cmd_dir_mask_i,
   input wire [DIV_W-1:0] cmd_div_i,
   // device bound fifo
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   output reg rx_ready_o,
   // host bound fifo
   output reg tx_valid_o,
   output reg [7:0] tx_data_o,
   input wire tx_ready_i,
   // parallel pins
   input wire [7:0] pin_i,
   output reg [7:0] pin_o,
   output reg [7:0] pin_oe_o,
   output reg pin_sample_strobe_n_o,
   output reg pin_update_strobe_n_o,
   // status
   output reg [7:0] mode_o
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SAMPLE = 3'h1;
   localparam ST_FWD = 3'h2;
   localparam ST_APPLY = 3'h3;
   localparam ST_SETUP = 3'h4;
   localparam ST_WSTB = 3'h5;

   reg [7:0] pin_s1_q;
   reg [7:0] pin_s2_q;
   reg [7:0] dir_q;
   reg [DIV_W-1:0] div_q;
   reg [2:0] st_q;
   reg [7:0] byte_q;
   reg [7:0] setup_cnt_q;
   reg smp_valid_q;
   reg [7:0] smp_q;
   wire tick;
   wire buf_ready;
   wire buf_valid;
   wire [7:0] buf_data;
   wire is_async;
   wire is_sync;
   wire take;
   integer i;

   assign is_async = (mode_o == `BBP_MODE_ASYNC);
   assign is_sync = (mode_o == `BBP_MODE_SYNC);

   bbp_baud_gen #(
      .DIV_W(DIV_W)
   ) u_baud (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(is_async),
      .div_i(div_q),
      .tick_o(tick)
   );

   bbp_skid_buf #(
      .WIDTH(8)
   ) u_buf (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(smp_valid_q),
      .in_data_i(smp_q),
      .in_ready_o(buf_ready),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(tx_ready_i || !tx_valid_o)
   );

   // accept a byte only while idle; async holds it until the next tick
   assign take = rx_valid_i && rx_ready_o && (st_q == ST_IDLE) &&
      (is_async || is_sync);

   // pin input synchroniser
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pin_s1_q <= 8'h00;
         pin_s2_q <= 8'h00;
      end else begin
         pin_s1_q <= pin_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   // host-bound output register
   always @(posedge core_clk_i) begin
      if (sys_rst_i || mode_o == `BBP_MODE_RESET) begin
         tx_valid_o <= 1'b0;
         tx_data_o <= 8'h00;
      end else if (tx_ready_i || !tx_valid_o) begin
         tx_valid_o <= buf_valid;
         tx_data_o <= buf_data;
      end
   end

   // output enables per pin
   always @(posedge core_clk_i) begin
      for (i = 0; i < 8; i = i + 1) begin
         if (sys_rst_i) begin
            pin_oe_o[i] <= 1'b0;
         end else begin
            pin_oe_o[i] <= dir_q[i] && (is_async || is_sync);
         end
      end
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         mode_o <= `BBP_MODE_RESET;
         dir_q <= `BBP_DIR_RESET;
         div_q <= `BBP_DIV_RESET;
      end else if (cmd_valid_i) begin
         mode_o <= cmd_mode_i;
         dir_q <= cmd_dir_mask_i;
         div_q <= cmd_div_i;
      end
   end

   always @(posedge core_clk_i) begin
      if (sys_rst_i || cmd_valid_i || mode_o == `BBP_MODE_RESET) begin
         st_q <= ST_IDLE;
         pin_o <= `BBP_PINS_RESET;
         byte_q <= 8'h00;
         setup_cnt_q <= 8'h00;
         smp_valid_q <= 1'b0;
         smp_q <= 8'h00;
         rx_ready_o <= 1'b0;
         pin_sample_strobe_n_o <= 1'b1;
         pin_update_strobe_n_o <= 1'b1;
      end else if (is_async) begin
         smp_valid_q <= 1'b0;
         pin_sample_strobe_n_o <= 1'b1;
         pin_update_strobe_n_o <= 1'b1;
         if (st_q == ST_IDLE) begin
            rx_ready_o <= !take;
            if (take) begin
               byte_q <= rx_data_i;
               st_q <= ST_APPLY;
            end
         end else if (tick) begin
            pin_o <= byte_q;
            pin_update_strobe_n_o <= 1'b0;
            st_q <= ST_IDLE;
         end
      end else if (is_sync) begin
         smp_valid_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               pin_update_strobe_n_o <= 1'b1;
               pin_sample_strobe_n_o <= 1'b0;
               rx_ready_o <= buf_ready && !smp_valid_q;
               if (take) begin
                  byte_q <= rx_data_i;
                  rx_ready_o <= 1'b0;
                  st_q <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               smp_q <= pin_s2_q;
               st_q <= ST_FWD;
            end
            ST_FWD: begin
               pin_sample_strobe_n_o <= 1'b1;
               smp_valid_q <= 1'b1;
               st_q <= ST_APPLY;
            end
            ST_APPLY: begin
               pin_sample_strobe_n_o <= 1'b0;
               pin_o <= byte_q;
               setup_cnt_q <= 8'h00;
               st_q <= ST_SETUP;
            end
            ST_SETUP: begin
               setup_cnt_q <= setup_cnt_q + 8'h01;
               if (setup_cnt_q + 8'h01 >= `BBP_SETUP_CYC) begin
                  st_q <= ST_WSTB;
               end
            end
            ST_WSTB: begin
               if (pin_update_strobe_n_o) begin
                  pin_update_strobe_n_o <= 1'b0;
               end else begin
                  pin_update_strobe_n_o <= 1'b1;
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end else begin
         rx_ready_o <= 1'b0;
         pin_sample_strobe_n_o <= 1'b1;
         pin_update_strobe_n_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/bbp_defines.vh */
// constants for the bit-bang parallel port
`ifndef BBP_DEFINES_VH
`define BBP_DEFINES_VH
`define BBP_MODE_RESET 8'h00
`define BBP_MODE_ASYNC 8'h01
`define BBP_MODE_SYNC 8'h04
`define BBP_DIR_RESET 8'h00
`define BBP_PINS_RESET 8'h00
`define BBP_DIV_RESET 16'h0001
`define BBP_SETUP_NS 20
`define BBP_CLK_NS 20
`define BBP_SETUP_CYC ((`BBP_SETUP_NS + `BBP_CLK_NS - 1) / `BBP_CLK_NS)
`endif

/* File: hdl/bbp_skid_buf.v */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bbp_skid_buf #(
   parameter WIDTH = 8
) (
   // clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // fill side
   input wire in_valid_i,
   input wire [WIDTH-1:0] in_data_i,
   output wire in_ready_o,
   // drain side
   output wire out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input wire out_ready_i
);
   reg [WIDTH-1:0] mem_q [0:1];
   reg wr_ptr_q;
   reg rd_ptr_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready_o = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o = mem_q[rd_ptr_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: hdl/bbp_baud_gen.v */
// baud rate tick generator with programmable divisor
`timescale 1ns/1ps
`default_nettype none
module bbp_baud_gen #(
   parameter DIV_W = 16
) (
   // clock and reset
   input wire core_clk_i,
   input wire sys_rst_i,
   // control
   input wire run_i,
   input wire [DIV_W-1:0] div_i,
   // tick
   output reg tick_o
);
   reg [DIV_W-1:0] cnt_q;
   always @(posedge core_clk_i) begin
      if (sys_rst_i || !run_i) begin
         cnt_q <= {DIV_W{1'b0}};
         tick_o <= 1'b0;
      end else if (cnt_q + {{(DIV_W-1){1'b0}}, 1'b1} >= div_i) begin
         cnt_q <= {DIV_W{1'b0}};
         tick_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/bbp_port_checker.sv */
// assertions on the bit-bang port streams and pins
`timescale 1ns/1ps
`default_nettype none
module bbp_port_checker (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // command and streams
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_mode_i,
   input wire logic [7:0] cmd_dir_mask_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_ready_o,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   // pins and status
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_o,
   input wire logic pin_sample_strobe_n_o,
   input wire logic pin_update_strobe_n_o,
   input wire logic [7:0] mode_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire take = rx_valid_i && rx_ready_o;
   logic [7:0] last_rx_q = 8'h00;
   always @(posedge core_clk_i) if (mode_o == 8'h01 && take) last_rx_q <= rx_data_i;
   sequence s_sync_take;
      mode_o == 8'h04 && take;
   endsequence
   sequence s_sync_steps;
      ##3 pin_sample_strobe_n_o ##1 !pin_sample_strobe_n_o
      ##2 !pin_update_strobe_n_o ##1 pin_update_strobe_n_o;
   endsequence
   a_strobes_idle: assert property ($fell(sys_rst_i) |->
      pin_sample_strobe_n_o && pin_update_strobe_n_o) else $error("strobes not idle");
   a_dir_load: assert property (cmd_valid_i && (cmd_mode_i == 8'h01 ||
      cmd_mode_i == 8'h04) |=> ##1 pin_oe_o == $past(cmd_dir_mask_i, 2)) else $error("bad mask");
   a_mode_select: assert property (cmd_valid_i && (cmd_mode_i == 8'h01 ||
      cmd_mode_i == 8'h04) |=> mode_o == $past(cmd_mode_i)) else $error("bad mode");
   a_mode_reset: assert property (cmd_valid_i && cmd_mode_i == 8'h00 |=>
      mode_o == 8'h00 ##1 pin_oe_o == 8'h00) else $error("mode 00 not reset");
   a_async_update: assert property (mode_o == 8'h01 && !pin_update_strobe_n_o |->
      (pin_o & pin_oe_o) == (last_rx_q & pin_oe_o)) else $error("async byte not applied");
   a_pins_hold: assert property ($changed(pin_o) |->
      !pin_update_strobe_n_o || $past(take, 4) || $past(cmd_valid_i)) else $error("pins moved");
   a_sync_order: assert property (s_sync_take |-> s_sync_steps)
      else $error("sync strobe order");
   a_sync_busy: assert property (s_sync_take |=> !rx_ready_o [*4])
      else $error("byte taken while busy");
   a_sample_hold: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o)) else $error("sample dropped");
endmodule
bind bbp_port bbp_port_checker u_checker (.*);
`default_nettype wire

/* File: testbench/bbp_pin_partner.sv */
// external logic on the pins, clocked by the update strobe
`timescale 1ns/1ps
`default_nettype none
module bbp_pin_partner (
   // pins from the port
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe_o,
   input wire logic pin_update_strobe_n_o,
   // pins seen by the port
   output logic [7:0] pin_i
);
   logic [7:0] ext_q = 8'h00;
   always @(posedge pin_update_strobe_n_o) ext_q <= ext_q + 8'h01;
   assign pin_i = (pin_o & pin_oe_o) | (ext_q & ~pin_oe_o);
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the bit-bang port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
   logic core_clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0;
   logic rx_valid_i = 1'b0, tx_ready_i = 1'b1;
   logic [7:0] cmd_mode_i = 8'h00, cmd_dir_mask_i = 8'h00, rx_data_i = 8'h00;
   logic [15:0] cmd_div_i = 16'h0004;
   wire rx_ready_o, tx_valid_o, pin_sample_strobe_n_o, pin_update_strobe_n_o;
   wire [7:0] tx_data_o, pin_i, pin_o, pin_oe_o, mode_o;
   int err_total = 0, n_tests = 0;
   logic [7:0] got_q[$];
   bbp_port uut (.core_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_mode_i, .cmd_dir_mask_i,
      .cmd_div_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o, .tx_data_o,
      .tx_ready_i, .pin_i, .pin_o, .pin_oe_o, .pin_sample_strobe_n_o,
      .pin_update_strobe_n_o, .mode_o);
   bbp_pin_partner u_partner (.pin_o, .pin_oe_o, .pin_update_strobe_n_o, .pin_i);
   initial forever #10 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (tx_valid_o === 1'b1 && tx_ready_i) got_q.push_back(tx_data_o);
   task automatic cmd(input logic [7:0] m, input logic [7:0] k);
      @(posedge core_clk_i) #1;
      cmd_valid_i = 1'b1;
      cmd_mode_i = m;
      cmd_dir_mask_i = k;
      @(posedge core_clk_i) #1;
      cmd_valid_i = 1'b0;
      repeat (2) @(posedge core_clk_i) #1;
   endtask
   task automatic send(input logic [7:0] b);
      int n;
      @(posedge core_clk_i) #1;
      rx_valid_i = 1'b1;
      rx_data_i = b;
      for (n = 0; n < 300 && rx_ready_o !== 1'b1; n++) @(posedge core_clk_i) #1;
      @(posedge core_clk_i) #1;
      rx_valid_i = 1'b0;
   endtask
   task automatic t_async;
      `CHK("strobes", 2'b11, {pin_sample_strobe_n_o, pin_update_strobe_n_o})
      cmd(8'h01, 8'hF0);
      `CHK("mode", 8'h01, mode_o)
      send(8'h5A);
      send(8'hC3);
      repeat (20) @(posedge core_clk_i);
      `CHK("pins", 8'hC0, pin_o & pin_oe_o)
      cmd(8'h00, 8'hFF);
      `CHK("oe off", 8'h00, pin_oe_o)
      $display("test async done");
   endtask
   task automatic t_sync;
      logic [7:0] exp_s[4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
      got_q.delete();
      cmd(8'h04, 8'hFF);
      tx_ready_i = 1'b0;
      fork
         begin
            send(8'hFF);
            send(8'h55);
            send(8'hAA);
            send(8'hAA);
         end
         begin
            repeat (60) @(posedge core_clk_i) #1;
            `CHK("refused", 1'b0, rx_ready_o)
            tx_ready_i = 1'b1;
         end
      join
      repeat (20) @(posedge core_clk_i);
      `CHK("count", 4, got_q.size())
      for (int i = 0; i < 4; i++) `CHK("sample", exp_s[i], got_q[i])
      $display("test sync done");
   endtask
   task automatic t_inputs;
      got_q.delete();
      cmd(8'h04, 8'h00);
      send(8'h33);
      repeat (6) @(posedge core_clk_i);
      send(8'h33);
      repeat (20) @(posedge core_clk_i);
      `CHK("oe", 8'h00, pin_oe_o)
      `CHK("in count", 2, got_q.size())
      `CHK("step", 8'h01, got_q[1] - got_q[0])
      $display("test inputs done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge core_clk_i) #1;
      sys_rst_i = 1'b0;
      t_async;
      t_sync;
      t_inputs;
      print_verdict;
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      err_total++;
      print_verdict;
   end
endmodule
`default_nettype wire
